// ### hdl/pin_sync.sv
/*
 * Two-flop synchronisers with a third stage for edge detection, one per bit.
 * Assumes the inputs are asynchronous pins; only stage two and three are read outside.
 */
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] sync_q,
    output logic      [WIDTH-1:0] prev_q
);

    ////////////////////////////////////////////////////////////////////////////////
    // Each bit gets its own chain; pins idle high, so the chains reset high.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_q;
            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    meta_q    <= 1'b1;
                    sync_q[i] <= 1'b1;
                    prev_q[i] <= 1'b1;
                end else begin
                    meta_q    <= pin_in[i];
                    sync_q[i] <= meta_q;
                    prev_q[i] <= sync_q[i];
                end
            end
        end
    endgenerate

endmodule // pin_sync

// ### hdl/temp_sensor_port.sv
/*
 * Two-wire serial slave of the on-board temperature sensor, with limit registers and alert pins.
 * Assumes a master clocking the bus well below the 40 MHz core clock and a same-domain temperature input.
 */
`timescale 1ns/1ps

module temp_sensor_port (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [15:0] temp_in,
    input  wire logic        range_pol_high,
    input  wire logic        critical_pol_high,
    output logic             range_alert_out,
    output logic             range_alert_oe,
    output logic             critical_alert_out,
    output logic             critical_alert_oe
);
    import temp_sensor_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // All state of the port in one record.
    typedef struct packed {
        port_state_t st;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic        rw;
        logic        first;
        logic        ack;
        logic [7:0]  ptr;
        logic        stale;
        logic        ptr_only;
        logic [15:0] high;
        logic [15:0] low;
        logic [15:0] crit;
        logic [15:0] snap;
        logic        sda_oe;
        logic        range_oe;
        logic        crit_oe;
    } port_reg_t;

    port_reg_t   q;
    port_reg_t   d;
    logic [1:0]  pin_s;
    logic [1:0]  pin_p;
    logic        scl_s;
    logic        sda_s;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_ev;
    logic        stop_ev;
    logic        range_hit;
    logic        crit_hit;
    logic        addr_hit;
    logic [7:0]  rd_byte;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus pins cross into the core domain before any decoding.
    pin_sync #(.WIDTH (2)) u_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .pin_in   ({scl_in, sda_in}),
        .sync_q   (pin_s),
        .prev_q   (pin_p)
    );

    // Edges and bus conditions; start and stop are data edges while the clock is high.
    assign scl_s    = pin_s[1];
    assign sda_s    = pin_s[0];
    assign scl_rise = pin_s[1] & ~pin_p[1];
    assign scl_fall = ~pin_s[1] & pin_p[1];
    assign start_ev = scl_s & pin_p[1] & ~pin_s[0] & pin_p[0];
    assign stop_ev  = scl_s & pin_p[1] & pin_s[0] & ~pin_p[0];
    assign addr_hit = (q.st == S_ADDR) && scl_fall && (q.cnt == BITS_PER_BYTE)
                      && (q.sh[7:1] == SLAVE_ADDR);

    // Limit comparisons are signed, matching the two's complement temperature word.
    assign range_hit = ($signed(temp_in) > $signed(q.high))
                       || ($signed(temp_in) < $signed(q.low));
    assign crit_hit  = $signed(temp_in) > $signed(q.crit);

    // Byte under the pointer; the high temperature byte is taken live, the low from the snapshot.
    always_comb begin
        unique case (q.ptr)
            TEMP_MSB: rd_byte = temp_in[15:8];
            TEMP_LSB: rd_byte = q.snap[7:0];
            HIGH_MSB: rd_byte = q.high[15:8];
            HIGH_LSB: rd_byte = q.high[7:0];
            LOW_MSB:  rd_byte = q.low[15:8];
            LOW_LSB:  rd_byte = q.low[7:0];
            CRIT_MSB: rd_byte = q.crit[15:8];
            CRIT_LSB: rd_byte = q.crit[7:0];
            default:  rd_byte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic of the serial engine, the registers and the alert pins.
    always_comb begin
        logic load;
        load = 1'b0;
        d    = q;
        // Alert pins are open drain: asserted means the level selected by the polarity input.
        d.range_oe = range_hit ^ range_pol_high;
        d.crit_oe  = crit_hit ^ critical_pol_high;
        if (start_ev) begin
            // A start in mid-transaction is a repeated start and keeps the pointer.
            d.st     = S_ADDR;
            d.cnt    = 4'h0;
            d.sda_oe = 1'b0;
        end else if (stop_ev) begin
            // A pointer written with no data and then stopped is no longer trusted.
            d.st       = S_IDLE;
            d.sda_oe   = 1'b0;
            d.stale    = q.stale | q.ptr_only;
            d.ptr_only = 1'b0;
        end else begin
            unique case (q.st)
                S_IDLE: d.cnt = 4'h0;
                S_ADDR: begin
                    if (scl_rise) begin
                        d.sh  = {q.sh[6:0], sda_s};
                        d.cnt = q.cnt + 4'h1;
                    end else if (addr_hit) begin
                        d.rw       = q.sh[0];
                        d.first    = 1'b1;
                        d.st       = S_ACK;
                        d.sda_oe   = 1'b1;
                        d.stale    = 1'b0;
                        d.ptr_only = 1'b0;
                        if (q.sh[0] && q.stale) begin
                            d.ptr = PTR_RESET;
                        end
                    end else if (scl_fall && (q.cnt == BITS_PER_BYTE)) begin
                        d.st = S_IDLE;
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        d.cnt    = 4'h0;
                        d.sda_oe = 1'b0;
                        d.st     = q.rw ? S_TX : S_RX;
                        load     = q.rw;
                    end
                end
                S_RX: begin
                    if (scl_rise) begin
                        d.sh  = {q.sh[6:0], sda_s};
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && (q.cnt == BITS_PER_BYTE)) begin
                        d.st     = S_ACK;
                        d.sda_oe = 1'b1;
                        if (q.first) begin
                            // First byte of a write sets the pointer.
                            d.ptr      = q.sh;
                            d.first    = 1'b0;
                            d.ptr_only = 1'b1;
                        end else begin
                            d.ptr_only = 1'b0;
                            unique case (q.ptr)
                                HIGH_MSB: d.high[15:8] = q.sh;
                                HIGH_LSB: d.high[7:0]  = q.sh;
                                LOW_MSB:  d.low[15:8]  = q.sh;
                                LOW_LSB:  d.low[7:0]   = q.sh;
                                CRIT_MSB: d.crit[15:8] = q.sh;
                                CRIT_LSB: d.crit[7:0]  = q.sh;
                                default:  d.sh         = q.sh;
                            endcase
                            if (q.ptr <= AUTO_INC_LAST) begin
                                d.ptr = q.ptr + 8'h01;
                            end
                        end
                    end
                end
                S_TX: begin
                    if (scl_rise) begin
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (q.cnt == BITS_PER_BYTE) begin
                            d.st     = S_MACK;
                            d.sda_oe = 1'b0;
                        end else begin
                            d.sh     = {q.sh[6:0], 1'b0};
                            d.sda_oe = ~q.sh[6];
                        end
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        d.ack = ~sda_s;
                    end else if (scl_fall) begin
                        d.cnt = 4'h0;
                        d.st  = q.ack ? S_TX : S_IDLE;
                        load  = q.ack;
                    end
                end
            endcase
        end
        // Load the next read byte and drive its first bit, most significant first.
        if (load) begin
            d.sh     = rd_byte;
            d.sda_oe = ~rd_byte[7];
            if (q.ptr == TEMP_MSB) begin
                d.snap = temp_in;
            end
            if (q.ptr <= AUTO_INC_LAST) begin
                d.ptr = q.ptr + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register; the pointer starts on the temperature high byte.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            q          <= '0;
            q.st       <= S_IDLE;
            q.ptr      <= PTR_RESET;
            q.high     <= HIGH_RESET;
            q.low      <= LOW_RESET;
            q.crit     <= CRIT_RESET;
        end else begin
            q <= d;
        end
    end

    // Open-drain pins only ever pull low, so the data side is a constant zero.
    assign sda_out            = 1'b0;
    assign sda_oe             = q.sda_oe;
    assign range_alert_out    = 1'b0;
    assign range_alert_oe     = q.range_oe;
    assign critical_alert_out = 1'b0;
    assign critical_alert_oe  = q.crit_oe;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the engine.
    property p_dir_read;
        @(posedge core_clk) disable iff (!reset_n)
        (q.st == S_ACK && scl_fall && !start_ev && !stop_ev && q.rw) |=> (q.st == S_TX);
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("Read direction did not start transmit.");
    property p_dir_write;
        @(posedge core_clk) disable iff (!reset_n)
        (q.st == S_ACK && scl_fall && !start_ev && !stop_ev && !q.rw) |=> (q.st == S_RX && !sda_oe);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("Write direction did not start receive.");
    property p_stale_clear;
        @(posedge core_clk) disable iff (!reset_n)
        (addr_hit && !start_ev && !stop_ev && q.sh[0] && q.stale) |=> (q.ptr == 8'h00 && !q.stale);
    endproperty
    a_stale_clear: assert property (p_stale_clear) else $error("Stale pointer was not cleared.");
    property p_auto_inc;
        @(posedge core_clk) disable iff (!reset_n)
        (q.st == S_MACK && scl_fall && q.ack && !start_ev && !stop_ev && q.ptr <= 8'h09)
        |=> (q.ptr == $past(q.ptr) + 8'h01);
    endproperty
    a_auto_inc: assert property (p_auto_inc) else $error("Pointer did not advance on read.");
    // The pin lags its inputs by one edge, so it is held against the polarity that was in force then.
    property p_range;
        @(posedge core_clk) disable iff (!reset_n)
        ($signed(temp_in) > $signed(q.high)) ##1 ($stable(range_pol_high) && $stable(q.high) && $stable(temp_in))
        |=> (range_alert_oe == ~$past(range_pol_high));
    endproperty
    a_range: assert property (p_range) else $error("Range alert wrong above high limit.");
    property p_crit;
        @(posedge core_clk) disable iff (!reset_n)
        (!crit_hit && !critical_pol_high) [*2] |=> (!critical_alert_oe);
    endproperty
    a_crit: assert property (p_crit) else $error("Critical alert driven below limit.");
    property p_reset_ptr;
        @(posedge core_clk) disable iff (1'b0)
        (!reset_n) |=> (q.ptr == 8'h00 && q.st == S_IDLE && !sda_oe);
    endproperty
    a_reset_ptr: assert property (p_reset_ptr) else $error("Pointer not on temperature after reset.");
    property p_msb_first;
        @(posedge core_clk) disable iff (!reset_n)
        (q.st == S_ACK && scl_fall && q.rw && !start_ev && !stop_ev && q.ptr == 8'h00)
        |=> (q.sh == $past(temp_in[15:8]) && q.snap == $past(temp_in) && q.ptr == 8'h01);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("Temperature high byte not sent first.");

endmodule // temp_sensor_port

// ### include/temp_sensor_pkg.sv
/*
 * Constants and types shared by the temperature sensor serial port.
 * Assumes one core clock domain; the two-wire bus pins are sampled, not clocked from.
 */
package temp_sensor_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus addressing and byte framing.
    localparam logic [6:0] SLAVE_ADDR    = 7'h4B;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    ////////////////////////////////////////////////////////////////////////////////
    // Register pointer values; each 16-bit value is a high byte followed by a low byte.
    localparam logic [7:0] PTR_RESET     = 8'h00;
    localparam logic [7:0] TEMP_MSB      = 8'h00;
    localparam logic [7:0] TEMP_LSB      = 8'h01;
    localparam logic [7:0] HIGH_MSB      = 8'h04;
    localparam logic [7:0] HIGH_LSB      = 8'h05;
    localparam logic [7:0] LOW_MSB       = 8'h06;
    localparam logic [7:0] LOW_LSB       = 8'h07;
    localparam logic [7:0] CRIT_MSB      = 8'h08;
    localparam logic [7:0] CRIT_LSB      = 8'h09;
    localparam logic [7:0] AUTO_INC_LAST = 8'h09;

    ////////////////////////////////////////////////////////////////////////////////
    // Limit values after reset, in the same 16-bit format as the temperature.
    localparam logic [15:0] HIGH_RESET   = 16'h2000;
    localparam logic [15:0] LOW_RESET    = 16'h0500;
    localparam logic [15:0] CRIT_RESET   = 16'h4980;

    // Serial engine states.
    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ACK,
        S_RX,
        S_TX,
        S_MACK
    } port_state_t;

endpackage

// ### testbench/bus_master_model.sv
/*
 * Behavioural two-wire bus master that drives the sensor port from the bench.
 * Assumes pull-ups on both wires, so it only ever pulls a wire low or lets it go.
 */
`timescale 1ns/1ps

module bus_master_model (
    input  wire logic core_clk,
    input  wire logic sda_wire,
    output logic      scl_low,
    output logic      sda_low
);
    ////////////////////////////////////////////////////////////////////////////////
    // Both wires start released, so the idle bus reads high.
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // A quarter bit is two core edges; changes land just after an edge.
    task automatic q();
        repeat (2) @(posedge core_clk);
        #2;
    endtask

    // Start or repeated start; the long wait lets the device drop its acknowledge first.
    task automatic start();
        scl_low = 1'b1;
        q();
        sda_low = 1'b0;
        q();
        q();
        scl_low = 1'b0;
        q();
        sda_low = 1'b1;
        q();
    endtask

    // Stop: data rises while the clock is high.
    task automatic stop();
        scl_low = 1'b1;
        q();
        sda_low = 1'b1;
        q();
        scl_low = 1'b0;
        q();
        sda_low = 1'b0;
        q();
    endtask

    // One bit slot: data set in the low phase, sampled in the middle of the high phase.
    task automatic bit_slot(input logic drive_low, output logic seen);
        scl_low = 1'b1;
        q();
        sda_low = drive_low;
        q();
        scl_low = 1'b0;
        q();
        seen = sda_wire;
        q();
    endtask

    // Sends a byte most significant bit first and returns the acknowledge level.
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(~b[i], s);
        end
        bit_slot(1'b0, ack);
    endtask

    // Reads a byte; all but the last are acknowledged, the last is refused.
    task automatic rd_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b0, b[i]);
        end
        bit_slot(~last, s);
    endtask
endmodule // bus_master_model

// ### testbench/testbench.sv
/*
 * Self-checking bench for the sensor serial port: register traffic and alert pins.
 * Assumes the bus master model beside it and pull-ups on every open-drain wire.
 */
`timescale 1ns/1ps

module testbench;
    import temp_sensor_pkg::*;
    logic        core_clk, reset_n, scl_low, sda_low, sda_out, sda_oe, a;
    logic        range_pol_high, critical_pol_high, range_alert_out, range_alert_oe;
    logic        critical_alert_out, critical_alert_oe, scl_wire, sda_wire, range_pin, crit_pin;
    logic [15:0] temp_in, t;
    logic [47:0] exp6;
    logic [7:0]  rx [0:5];
    int          failures, n_tests, cycles;

    ////////////////////////////////////////////////////////////////////////////////
    // Open-drain wires with pull-ups: any party pulling low wins.
    assign scl_wire  = ~scl_low;
    assign sda_wire  = (sda_oe ? sda_out : 1'b1) & ~sda_low;
    assign range_pin = range_alert_oe ? range_alert_out : 1'b1;
    assign crit_pin  = critical_alert_oe ? critical_alert_out : 1'b1;

    temp_sensor_port temp_sensor_port_inst (.core_clk(core_clk), .reset_n(reset_n), .scl_in(scl_wire),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .temp_in(temp_in),
        .range_pol_high(range_pol_high), .critical_pol_high(critical_pol_high),
        .range_alert_out(range_alert_out), .range_alert_oe(range_alert_oe),
        .critical_alert_out(critical_alert_out), .critical_alert_oe(critical_alert_oe));
    bus_master_model bus_master_model_inst (.core_clk(core_clk), .sda_wire(sda_wire),
        .scl_low(scl_low), .sda_low(sda_low));

    // Core clock at 40 MHz; the hang guard is far above the fewer than two thousand cycles needed.
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Addresses the device for writing and sends the register pointer.
    task automatic set_ptr(input logic [7:0] ptr);
        bus_master_model_inst.start();
        bus_master_model_inst.wr_byte({SLAVE_ADDR, 1'b0}, a);
        check("write address ack", {15'h0000, a}, 16'h0000);
        bus_master_model_inst.wr_byte(ptr, a);
        check("pointer ack", {15'h0000, a}, 16'h0000);
    endtask

    // Addresses the device for reading and collects n bytes, then stops.
    task automatic read_bytes(input int n);
        bus_master_model_inst.start();
        bus_master_model_inst.wr_byte({SLAVE_ADDR, 1'b1}, a);
        check("read address ack", {15'h0000, a}, 16'h0000);
        for (int i = 0; i < n; i++) begin
            bus_master_model_inst.rd_byte(i == n - 1, rx[i]);
        end
        bus_master_model_inst.stop();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        core_clk          = 1'b0;
        reset_n           = 1'b0;
        temp_in           = 16'h0C80;
        range_pol_high    = 1'b0;
        critical_pol_high = 1'b0;
        failures          = 0;
        n_tests           = 0;
        cycles            = 0;
        repeat (5) @(posedge core_clk);
        #2 reset_n = 1'b1;
        repeat (6) @(posedge core_clk);
        #2;
        // Plain read after reset gives the temperature, high byte first.
        read_bytes(2);
        check("temp msb", {8'h00, rx[0]}, {8'h00, temp_in[15:8]});
        check("temp lsb", {8'h00, rx[1]}, {8'h00, temp_in[7:0]});
        check("celsius x16", 16'($signed({rx[0], rx[1]}) >>> 3), 16'h0190);
        $display("test power_up_read done");
        // Two data bytes in one write, then six bytes read across three limit pairs.
        set_ptr(HIGH_MSB);
        bus_master_model_inst.wr_byte(8'h12, a);
        check("data ack msb", {15'h0000, a}, 16'h0000);
        bus_master_model_inst.wr_byte(8'h34, a);
        check("data ack lsb", {15'h0000, a}, 16'h0000);
        bus_master_model_inst.stop();
        set_ptr(HIGH_MSB);
        read_bytes(6);
        exp6 = {16'h1234, LOW_RESET, CRIT_RESET};
        for (int i = 0; i < 6; i++) begin
            check("limit byte", {8'h00, rx[i]}, {8'h00, exp6[47 - 8 * i -: 8]});
        end
        $display("test limit_pairs done");
        // Another address on the bus is left unanswered.
        bus_master_model_inst.start();
        bus_master_model_inst.wr_byte({SLAVE_ADDR ^ 7'h01, 1'b1}, a);
        check("foreign address nack", {15'h0000, a}, 16'h0001);
        bus_master_model_inst.stop();
        $display("test foreign_address done");
        // A pointer write closed by stop leaves the next read at the temperature.
        set_ptr(LOW_MSB);
        bus_master_model_inst.stop();
        read_bytes(2);
        check("stale pointer msb", {8'h00, rx[0]}, {8'h00, temp_in[15:8]});
        check("stale pointer lsb", {8'h00, rx[1]}, {8'h00, temp_in[7:0]});
        $display("test stale_pointer done");
        // Alert pins for in-window, high, critical and negative temperatures, both polarities.
        for (int k = 0; k < 8; k++) begin
            t = (k[2:1] == 2'h0) ? 16'h0800 : (k[2:1] == 2'h1) ? 16'h2000 :
                (k[2:1] == 2'h2) ? 16'h5000 : 16'hFF00;
            temp_in           = t;
            range_pol_high    = k[0];
            critical_pol_high = ~k[0];
            repeat (4) @(posedge core_clk);
            #2;
            if ($signed(t) > $signed(16'h1234) || $signed(t) < $signed(LOW_RESET)) begin
                check("range pin", {15'h0000, range_pin}, {15'h0000, k[0]});
            end else begin
                check("range pin", {15'h0000, range_pin}, {15'h0000, ~k[0]});
            end
            if ($signed(t) > $signed(CRIT_RESET)) begin
                check("critical pin", {15'h0000, crit_pin}, {15'h0000, ~k[0]});
            end else begin
                check("critical pin", {15'h0000, crit_pin}, {15'h0000, k[0]});
            end
        end
        $display("test alert_pins done");
        results();
    end
endmodule // testbench
